// ### ril_link_if.sv
// Signals between the controller, the press timer and the pacer
`timescale 1ns/1ps
`default_nettype none
interface ril_link_if;
  logic btn;
  logic rel_ok;
  logic too_long;
  logic short_flt;
  logic flash;
  logic pin_free;
  logic sample;
  modport timer (input btn, output rel_ok, output too_long, output short_flt);
  modport pacer (output flash, output pin_free, output sample);
  modport ctrl (output btn, input rel_ok, input too_long, input short_flt, input flash, input pin_free,
    input sample);
endinterface : ril_link_if
`default_nettype wire

// ### ril_pacer.sv
// Lamp flash phase and scan window for the shared reset pin
`timescale 1ns/1ps
`default_nettype none
module ril_pacer #(
  parameter int CW = ril_pkg::CNT_W,
  parameter logic [CW-1:0] FLASH_HALF = CW'(ril_pkg::FLASH_HALF_CYC),
  parameter int PERIOD = ril_pkg::SCAN_PERIOD,
  parameter int WIN = ril_pkg::SCAN_WIN
) (
  input wire logic clk,
  input wire logic arst_n,
  ril_link_if.pacer lk
);
  localparam int SW = $clog2(PERIOD);
  localparam logic [SW-1:0] SCAN_LAST = SW'(PERIOD - 1);
  localparam logic [SW-1:0] SCAN_FREE = SW'(PERIOD - WIN);
  typedef struct packed {
    logic [SW-1:0] scan;
    logic [CW-1:0] fcnt;
    logic flash;
    logic pin_free;
    logic sample;
  } ril_pace_st_t;
  ril_pace_st_t st_ff;
  ril_pace_st_t nxt_st;

  // Free-running counters; the pin is released late in each period
  always_comb begin
    nxt_st = st_ff;
    nxt_st.scan = (st_ff.scan == SCAN_LAST) ? '0 : st_ff.scan + 1'b1;
    nxt_st.pin_free = nxt_st.scan >= SCAN_FREE;
    nxt_st.sample = nxt_st.scan == SCAN_LAST; // Last cycle: synchroniser has settled
    if (st_ff.fcnt == '0) begin
      nxt_st.fcnt = FLASH_HALF - 1'b1;
      nxt_st.flash = ~st_ff.flash;
    end else begin
      nxt_st.fcnt = st_ff.fcnt - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign lk.flash = st_ff.flash;
  assign lk.pin_free = st_ff.pin_free;
  assign lk.sample = st_ff.sample;
endmodule : ril_pacer
`default_nettype wire

// ### ril_partner.sv
// Model of the reset button and the downstream safety relay
`timescale 1ns/1ps
`default_nettype none
module ril_partner (
  input wire logic clk,
  input wire logic press,
  input wire logic pin_o,
  input wire logic pin_oe,
  input wire logic out_a,
  input wire logic out_b,
  output logic pin_i,
  output var int split_cnt
);
  // Closed button ties the pin to supply and beats the driver; the lamp load pulls an idle pin low
  assign pin_i = press ? 1'b1 : (pin_oe ? pin_o : 1'b0);
  // Relay counts cycles where the two channels disagree
  initial split_cnt = 0;
  always @(posedge clk) begin
    if (out_a !== out_b) split_cnt <= split_cnt + 1;
  end
endmodule : ril_partner
`default_nettype wire

// ### ril_pkg.sv
// Constants, types and timing for the restart interlock controller
// Contract
// R1: Red lamp lit while restart is locked
// R2: Yellow lamp when field clear and interlock enabled
// R3: Press released within 0.15-4 s unlocks
// R4: Press held 4 s or longer is discarded
// R5: Press held 30 s means short: fault
// R6: Field free, no lock: steady green, outputs on
// R7: Alignment enabled: flashing segments show quality
// R8: Reduced margin flashes green; lost reception red
// R9: Interruption or power loss keeps outputs off
// R10: Installer straps select input or bridges it
// R11: Reset pin reads button, drives inverted outputs
// R12: Self test, then response time display
// R13: Press shorter than 0.15 s is ignored
// R14: Both outputs switch together, same cycle
`default_nettype none
package ril_pkg;
  // Clock rate and documented times
  localparam longint unsigned CLK_KHZ = 125000;
  localparam longint unsigned MIN_PRESS_MS = 150;
  localparam longint unsigned MAX_PRESS_MS = 4000;
  localparam longint unsigned SHORT_MS = 30000;
  localparam longint unsigned SELFTEST_MS = 100;
  localparam longint unsigned RT_SHOW_MS = 1000;
  localparam longint unsigned FLASH_HALF_MS = 250;
  // Derived cycle counts; exact products, so no rounding needed
  localparam longint unsigned MIN_PRESS_CYC = MIN_PRESS_MS * CLK_KHZ;
  localparam longint unsigned MAX_PRESS_CYC = MAX_PRESS_MS * CLK_KHZ;
  localparam longint unsigned SHORT_CYC = SHORT_MS * CLK_KHZ;
  localparam longint unsigned SELFTEST_CYC = SELFTEST_MS * CLK_KHZ;
  localparam longint unsigned RT_SHOW_CYC = RT_SHOW_MS * CLK_KHZ;
  localparam longint unsigned FLASH_HALF_CYC = FLASH_HALF_MS * CLK_KHZ;
  localparam int CNT_W = 32;
  // Shared pin scan: released for the last SCAN_WIN cycles of each period
  localparam int SCAN_PERIOD = 64;
  localparam int SCAN_WIN = 8;
  // Register map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam int CTRL_ALIGN_BIT = 0;
  localparam logic CTRL_ALIGN_RST = 1'b0;
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_OUT_BIT = 3;
  localparam int STAT_RES_BIT = 4;
  localparam int STAT_BTN_BIT = 5;
  localparam int STAT_FLT_BIT = 6;
  localparam logic [3:0] RESP_DIGIT_DEF = 4'h0;
  typedef enum logic [2:0] {ST_SELFTEST, ST_SHOW_RT, ST_LOCKED, ST_ON, ST_FAULT} ril_mode_t;
endpackage : ril_pkg
`default_nettype wire

// ### ril_press_timer.sv
// Measures reset button presses and flags valid, overlong and stuck presses
`timescale 1ns/1ps
`default_nettype none
module ril_press_timer #(
  parameter int CW = ril_pkg::CNT_W,
  parameter logic [CW-1:0] MIN_CYC = CW'(ril_pkg::MIN_PRESS_CYC),
  parameter logic [CW-1:0] MAX_CYC = CW'(ril_pkg::MAX_PRESS_CYC),
  parameter logic [CW-1:0] SHORT_CYC = CW'(ril_pkg::SHORT_CYC)
) (
  input wire logic clk,
  input wire logic arst_n,
  ril_link_if.timer lk
);
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic prev;
    logic rel_ok;
    logic too_long;
    logic short_flt;
  } ril_press_st_t;
  ril_press_st_t st_ff;
  ril_press_st_t nxt_st;

  // Count while held; judge the press on its release edge
  always_comb begin
    nxt_st = st_ff;
    nxt_st.prev = lk.btn;
    nxt_st.rel_ok = 1'b0;
    if (lk.btn) begin
      if (st_ff.cnt != SHORT_CYC) begin
        nxt_st.cnt = st_ff.cnt + 1'b1; // Saturates, never wraps back to a valid window
      end
      if (nxt_st.cnt >= MAX_CYC) begin
        nxt_st.too_long = 1'b1; // R4
      end
      if (nxt_st.cnt == SHORT_CYC) begin
        nxt_st.short_flt = 1'b1; // R5
      end
    end else begin
      if (st_ff.prev) begin
        nxt_st.rel_ok = (st_ff.cnt >= MIN_CYC) && (st_ff.cnt < MAX_CYC); // R3 R4 R13
      end
      nxt_st.cnt = '0;
      nxt_st.too_long = 1'b0;
    end
  end

  // Short flag is sticky: only the arst_n reset clears a stuck input
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign lk.rel_ok = st_ff.rel_ok;
  assign lk.too_long = st_ff.too_long;
  assign lk.short_flt = st_ff.short_flt;

  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  short_press_a: assert property ((!lk.btn && st_ff.prev && st_ff.cnt < MIN_CYC) |=> !lk.rel_ok) // R13
    else $error("short press accepted");
  long_press_a: assert property ((!lk.btn && st_ff.prev && st_ff.cnt >= MAX_CYC) |=> !lk.rel_ok) // R4
    else $error("overlong press accepted");
  press_window_a: assert property ((!lk.btn && st_ff.prev && st_ff.cnt >= MIN_CYC && st_ff.cnt < MAX_CYC) // R3
    |=> lk.rel_ok && !lk.too_long)
    else $error("valid press not accepted");
  stuck_input_a: assert property ((lk.btn && st_ff.cnt == SHORT_CYC - 1'b1) |=> lk.short_flt) // R5
    else $error("stuck input not flagged");
endmodule : ril_press_timer
`default_nettype wire

// ### ril_restart_ctrl.sv
// Restart interlock, safety outputs, status lamps and register port
`timescale 1ns/1ps
`default_nettype none
module ril_restart_ctrl #(
  parameter int CW = ril_pkg::CNT_W,
  parameter longint unsigned MIN_PRESS_CYC = ril_pkg::MIN_PRESS_CYC,
  parameter longint unsigned MAX_PRESS_CYC = ril_pkg::MAX_PRESS_CYC,
  parameter longint unsigned SHORT_CYC = ril_pkg::SHORT_CYC,
  parameter longint unsigned SELFTEST_CYC = ril_pkg::SELFTEST_CYC,
  parameter longint unsigned RT_SHOW_CYC = ril_pkg::RT_SHOW_CYC,
  parameter longint unsigned FLASH_HALF_CYC = ril_pkg::FLASH_HALF_CYC,
  parameter logic [3:0] RESP_DIGIT = ril_pkg::RESP_DIGIT_DEF
) (
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  input wire logic FIELD_CLEAR,
  input wire logic MARGIN_LOW,
  input wire logic [2:0] ALIGN_QUALITY,
  input wire logic LOCK_SELECT_INPUT,
  input wire logic RESET_BUTTON_PIN_I,
  output logic RESET_BUTTON_PIN_O,
  output logic RESET_BUTTON_PIN_OE,
  output logic SAFETY_SWITCH_OUT_A,
  output logic SAFETY_SWITCH_OUT_B,
  output logic LAMP_RED,
  output logic LAMP_YELLOW,
  output logic LAMP_GREEN,
  output logic [6:0] SEGMENTS,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA
);
  localparam logic [CW-1:0] SELFTEST_C = CW'(SELFTEST_CYC);
  localparam logic [CW-1:0] RT_SHOW_C = CW'(RT_SHOW_CYC);

  typedef struct packed {
    ril_pkg::ril_mode_t mode;
    logic [CW-1:0] tmr;
    logic pin_s1;
    logic pin_s2;
    logic sel_s1;
    logic sel_s2;
    logic btn;
    logic res_en;
    logic safety_switch_output;
    logic red;
    logic yellow;
    logic green;
    logic [6:0] seg;
    logic pin_o;
    logic pin_oe;
    logic align_en;
    logic [7:0] rdata;
  } ril_top_st_t;

  localparam ril_top_st_t ST_RST = '{mode: ril_pkg::ST_SELFTEST, tmr: SELFTEST_C, pin_oe: 1'b1, red: 1'b1,
    align_en: ril_pkg::CTRL_ALIGN_RST, default: '0};

  ril_top_st_t st_ff;
  ril_top_st_t nxt_st;

  ril_link_if lk ();

  // Digit pattern for the response time shown after self test
  function automatic logic [6:0] seg_digit(input logic [3:0] d);
    case (d)
      4'h0: seg_digit = 7'h3f;
      4'h1: seg_digit = 7'h06;
      4'h2: seg_digit = 7'h5b;
      4'h3: seg_digit = 7'h4f;
      4'h4: seg_digit = 7'h66;
      4'h5: seg_digit = 7'h6d;
      4'h6: seg_digit = 7'h7d;
      4'h7: seg_digit = 7'h07;
      4'h8: seg_digit = 7'h7f;
      4'h9: seg_digit = 7'h6f;
      default: seg_digit = 7'h40;
    endcase
  endfunction : seg_digit

  // Bar of lit segments, longer for better alignment
  function automatic logic [6:0] seg_bar(input logic [2:0] q);
    seg_bar = 7'(8'hff >> (4'h8 - {1'b0, q}));
  endfunction : seg_bar

  ril_press_timer #(
    .CW(CW),
    .MIN_CYC(CW'(MIN_PRESS_CYC)),
    .MAX_CYC(CW'(MAX_PRESS_CYC)),
    .SHORT_CYC(CW'(SHORT_CYC))
  ) u_press (
    .clk(CORE_CLK),
    .arst_n(ARST_N),
    .lk(lk.timer)
  );

  ril_pacer #(
    .CW(CW),
    .FLASH_HALF(CW'(FLASH_HALF_CYC)),
    .PERIOD(ril_pkg::SCAN_PERIOD),
    .WIN(ril_pkg::SCAN_WIN)
  ) u_pace (
    .clk(CORE_CLK),
    .arst_n(ARST_N),
    .lk(lk.pacer)
  );

  assign lk.btn = st_ff.btn;

  // Mode sequence, lamps, pin drive and register port
  always_comb begin
    nxt_st = st_ff;
    nxt_st.pin_s1 = RESET_BUTTON_PIN_I;
    nxt_st.pin_s2 = st_ff.pin_s1;
    nxt_st.sel_s1 = LOCK_SELECT_INPUT;
    nxt_st.sel_s2 = st_ff.sel_s1;
    if (lk.sample) begin
      nxt_st.btn = st_ff.pin_s2; // Read while the pin is released, or while it is driven low in self test
    end
    nxt_st.tmr = (st_ff.tmr == '0) ? '0 : st_ff.tmr - 1'b1;
    case (st_ff.mode)
      ril_pkg::ST_SELFTEST: begin
        if (st_ff.tmr == '0) begin
          // Pin is held low here, so a bridged select reads low
          nxt_st.res_en = st_ff.sel_s2; // R10
          nxt_st.mode = ril_pkg::ST_SHOW_RT; // R12
          nxt_st.tmr = RT_SHOW_C;
        end
      end
      ril_pkg::ST_SHOW_RT: begin
        if (st_ff.tmr == '0) begin
          // Power-up counts as an interruption when locking is on
          nxt_st.mode = st_ff.res_en ? ril_pkg::ST_LOCKED : ril_pkg::ST_ON; // R9
        end
      end
      ril_pkg::ST_LOCKED: begin
        if (lk.rel_ok && FIELD_CLEAR) begin
          nxt_st.mode = ril_pkg::ST_ON; // R3
        end
      end
      ril_pkg::ST_ON: begin
        if (!FIELD_CLEAR && st_ff.res_en) begin
          nxt_st.mode = ril_pkg::ST_LOCKED; // R9
        end
      end
      ril_pkg::ST_FAULT: begin
        nxt_st.mode = ril_pkg::ST_FAULT;
      end
      default: begin
        nxt_st.mode = ril_pkg::ST_FAULT;
      end
    endcase
    if (lk.short_flt && st_ff.res_en && st_ff.mode != ril_pkg::ST_SELFTEST && st_ff.mode != ril_pkg::ST_SHOW_RT) begin
      nxt_st.mode = ril_pkg::ST_FAULT; // R5
    end
    // One bit feeds both outputs; field loss drops it on the next edge
    nxt_st.safety_switch_output = (nxt_st.mode == ril_pkg::ST_ON) && FIELD_CLEAR; // R6 R14
    nxt_st.red = !nxt_st.safety_switch_output; // R1 R8
    nxt_st.green = nxt_st.safety_switch_output && (!MARGIN_LOW || lk.flash); // R6 R8
    nxt_st.yellow = (nxt_st.mode == ril_pkg::ST_LOCKED) && FIELD_CLEAR && st_ff.res_en; // R2
    if (nxt_st.mode == ril_pkg::ST_SHOW_RT) begin
      nxt_st.seg = seg_digit(RESP_DIGIT); // R12
    end else if (st_ff.align_en && lk.flash
        && (nxt_st.mode == ril_pkg::ST_LOCKED || nxt_st.mode == ril_pkg::ST_ON)) begin
      nxt_st.seg = seg_bar(ALIGN_QUALITY); // R7
    end else begin
      nxt_st.seg = 7'h00;
    end
    // Lamp drive shares the pin, so it is interrupted to sample the button
    if (nxt_st.mode == ril_pkg::ST_SELFTEST) begin
      nxt_st.pin_oe = 1'b1;
      nxt_st.pin_o = 1'b0;
    end else begin
      nxt_st.pin_oe = !lk.pin_free;
      nxt_st.pin_o = !nxt_st.safety_switch_output; // R11
    end
    if (REG_WR && REG_ADDR == ril_pkg::ADDR_CTRL) begin
      nxt_st.align_en = REG_WDATA[ril_pkg::CTRL_ALIGN_BIT];
    end
    nxt_st.rdata = 8'h00;
    if (REG_RD && REG_ADDR == ril_pkg::ADDR_CTRL) begin
      nxt_st.rdata[ril_pkg::CTRL_ALIGN_BIT] = st_ff.align_en;
    end else if (REG_RD && REG_ADDR == ril_pkg::ADDR_STATUS) begin
      nxt_st.rdata[ril_pkg::STAT_MODE_LSB +: 3] = st_ff.mode;
      nxt_st.rdata[ril_pkg::STAT_OUT_BIT] = st_ff.safety_switch_output;
      nxt_st.rdata[ril_pkg::STAT_RES_BIT] = st_ff.res_en;
      nxt_st.rdata[ril_pkg::STAT_BTN_BIT] = st_ff.btn;
      nxt_st.rdata[ril_pkg::STAT_FLT_BIT] = lk.short_flt;
    end
  end

  // Reset leaves outputs, display and other lamps off, red lamp lit and the pin driven low
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_ff <= ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign SAFETY_SWITCH_OUT_A = st_ff.safety_switch_output;
  assign SAFETY_SWITCH_OUT_B = st_ff.safety_switch_output;
  assign LAMP_RED = st_ff.red;
  assign LAMP_YELLOW = st_ff.yellow;
  assign LAMP_GREEN = st_ff.green;
  assign SEGMENTS = st_ff.seg;
  assign RESET_BUTTON_PIN_O = st_ff.pin_o;
  assign RESET_BUTTON_PIN_OE = st_ff.pin_oe;
  assign REG_RDATA = st_ff.rdata;

  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);
  // Lamps and safety outputs against the interlock mode
  red_locked_a: assert property (st_ff.mode == ril_pkg::ST_LOCKED |-> LAMP_RED && !SAFETY_SWITCH_OUT_A) // R1
    else $error("locked without red lamp");
  // A stuck-input fault in the same cycle legitimately drops the lamp
  yellow_ready_a: assert property ((st_ff.mode == ril_pkg::ST_LOCKED && FIELD_CLEAR && !lk.rel_ok // R2
    && !lk.short_flt) |=> LAMP_YELLOW == st_ff.res_en)
    else $error("yellow lamp wrong while locked");
  yellow_only_a: assert property (LAMP_YELLOW |-> st_ff.mode == ril_pkg::ST_LOCKED && st_ff.res_en) // R2
    else $error("yellow lamp outside locked state");
  unlock_on_a: assert property ((st_ff.mode == ril_pkg::ST_LOCKED && lk.rel_ok && FIELD_CLEAR // R3
    && !lk.short_flt) |=> SAFETY_SWITCH_OUT_A && st_ff.mode == ril_pkg::ST_ON)
    else $error("valid press did not unlock");
  fault_entry_a: assert property ((lk.short_flt && st_ff.res_en // R5
    && st_ff.mode inside {ril_pkg::ST_LOCKED, ril_pkg::ST_ON})
    |=> st_ff.mode == ril_pkg::ST_FAULT ##1 !SAFETY_SWITCH_OUT_A)
    else $error("stuck input did not fault");
  // Fault is left only through reset
  fault_hold_a: assert property (st_ff.mode == ril_pkg::ST_FAULT // R5
    |=> st_ff.mode == ril_pkg::ST_FAULT && !SAFETY_SWITCH_OUT_A)
    else $error("fault state left without reset");
  green_steady_a: assert property ((st_ff.mode == ril_pkg::ST_ON && FIELD_CLEAR && !MARGIN_LOW // R6
    && !lk.short_flt) |=> LAMP_GREEN && SAFETY_SWITCH_OUT_A && !LAMP_RED)
    else $error("free field not green");
  // Without the interlock a field break never locks
  open_on_a: assert property ((!st_ff.res_en && st_ff.mode == ril_pkg::ST_ON) // R6
    |=> st_ff.mode == ril_pkg::ST_ON)
    else $error("locked with interlock disabled");
  margin_flash_a: assert property ((st_ff.mode == ril_pkg::ST_ON && FIELD_CLEAR && MARGIN_LOW // R8
    && !lk.short_flt) |=> LAMP_GREEN == $past(lk.flash))
    else $error("reduced margin not flashing");
  lost_red_a: assert property ((!FIELD_CLEAR && st_ff.mode != ril_pkg::ST_SELFTEST) // R8 R14
    |=> LAMP_RED && !LAMP_GREEN && !SAFETY_SWITCH_OUT_A)
    else $error("lost reception not red");
  stay_locked_a: assert property ((st_ff.mode == ril_pkg::ST_LOCKED && !lk.rel_ok) |=> !SAFETY_SWITCH_OUT_A) // R9
    else $error("outputs on without valid press");
  // Shared pin: lamp level while driven, released for the scan
  pin_lamp_a: assert property ((RESET_BUTTON_PIN_OE && st_ff.mode != ril_pkg::ST_SELFTEST) // R11
    |-> RESET_BUTTON_PIN_O != SAFETY_SWITCH_OUT_B)
    else $error("pin lamp not inverted");
  pin_release_a: assert property ((lk.pin_free && st_ff.mode != ril_pkg::ST_SELFTEST) // R11
    |=> !RESET_BUTTON_PIN_OE)
    else $error("pin not released for scan");
  selftest_off_a: assert property (st_ff.mode == ril_pkg::ST_SELFTEST // R12
    |-> !SAFETY_SWITCH_OUT_A && RESET_BUTTON_PIN_OE && !RESET_BUTTON_PIN_O)
    else $error("outputs active in self test");
  // Display: response digit first, then alignment bar or dark
  show_digit_a: assert property (st_ff.mode == ril_pkg::ST_SHOW_RT // R12
    |-> SEGMENTS == seg_digit(RESP_DIGIT))
    else $error("response time not shown");
  seg_dark_a: assert property ((!st_ff.align_en // R7
    && st_ff.mode inside {ril_pkg::ST_LOCKED, ril_pkg::ST_ON, ril_pkg::ST_FAULT}) |=> SEGMENTS == 7'h00)
    else $error("display lit while disabled");
  bar_shown_a: assert property ((st_ff.align_en && lk.flash && !lk.short_flt // R7
    && st_ff.mode inside {ril_pkg::ST_LOCKED, ril_pkg::ST_ON}) |=> SEGMENTS == seg_bar($past(ALIGN_QUALITY)))
    else $error("alignment bar not shown");
  outputs_pair_a: assert property (SAFETY_SWITCH_OUT_A == SAFETY_SWITCH_OUT_B) // R14
    else $error("safety outputs differ");
  // Read data stands one cycle only, then returns to zero
  rdata_idle_a: assert property (!REG_RD |=> REG_RDATA == 8'h00)
    else $error("read data outside read cycle");
  unlock_c: cover property (st_ff.mode == ril_pkg::ST_LOCKED ##1 st_ff.mode == ril_pkg::ST_ON);
  fault_c: cover property (st_ff.mode == ril_pkg::ST_FAULT);
  margin_c: cover property (SAFETY_SWITCH_OUT_A && !LAMP_GREEN);
  show_c: cover property (st_ff.mode == ril_pkg::ST_SHOW_RT ##1 st_ff.mode == ril_pkg::ST_LOCKED);
  open_c: cover property (!st_ff.res_en && SAFETY_SWITCH_OUT_A);
endmodule : ril_restart_ctrl
`default_nettype wire

// ### ril_restart_ctrl_tb.sv
// Self-checking bench for the restart interlock controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module ril_restart_ctrl_tb;
  localparam int MIN_C = 640;
  localparam int MAX_C = 2560;
  localparam int SHORT_C = 6400;
  logic clk, arst_n, field_clear, margin_low, lock_sel, press, reg_wr, reg_rd;
  logic pin_i, pin_o, pin_oe, out_a, out_b, red, yel, grn;
  logic [2:0] align_q;
  logic [6:0] segs;
  logic [7:0] reg_addr, reg_wdata, rdata, d;
  int mismatches, checks_done, cyc, split_cnt, n_hi, n_lo;
  ril_restart_ctrl #(.MIN_PRESS_CYC(MIN_C), .MAX_PRESS_CYC(MAX_C), .SHORT_CYC(SHORT_C),
    .SELFTEST_CYC(10), .RT_SHOW_CYC(10), .FLASH_HALF_CYC(8)) uut (
    .CORE_CLK(clk), .ARST_N(arst_n), .FIELD_CLEAR(field_clear), .MARGIN_LOW(margin_low),
    .ALIGN_QUALITY(align_q), .LOCK_SELECT_INPUT(lock_sel), .RESET_BUTTON_PIN_I(pin_i),
    .RESET_BUTTON_PIN_O(pin_o), .RESET_BUTTON_PIN_OE(pin_oe), .SAFETY_SWITCH_OUT_A(out_a),
    .SAFETY_SWITCH_OUT_B(out_b), .LAMP_RED(red), .LAMP_YELLOW(yel), .LAMP_GREEN(grn),
    .SEGMENTS(segs), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
    .REG_RD(reg_rd), .REG_RDATA(rdata));
  ril_partner prt (.clk(clk), .press(press), .pin_o(pin_o), .pin_oe(pin_oe), .out_a(out_a),
    .out_b(out_b), .pin_i(pin_i), .split_cnt(split_cnt));
  // 125 MHz core clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic end_of_test();
    $display("checks_done %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  // Hang guard, well above the longest expected run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      mismatches++;
      end_of_test();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic reg_wr_t(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : reg_wr_t
  // Read data stands only in the cycle after the strobe
  task automatic reg_rd_t(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = rdata;
  endtask : reg_rd_t
  // Press, release, then leave a few scan periods for the accept pulse
  task automatic push(input int len);
    @(posedge clk);
    press <= 1'b1;
    tick(len);
    press <= 1'b0;
    tick(200);
  endtask : push
  task automatic chk_state(input logic on, input logic yel_e);
    #1;
    `CHK("out_a", on, out_a)
    `CHK("out_b", on, out_b)
    `CHK("red", ~on, red)
    `CHK("yellow", yel_e, yel)
    `CHK("green", on, grn)
    if (pin_oe === 1'b1) `CHK("lamp", ~on, pin_o)
  endtask : chk_state
  function automatic logic [6:0] bar(input logic [2:0] q);
    return 7'((8'h01 << q) - 8'h01);
  endfunction : bar
  initial begin
    {arst_n, margin_low, press, reg_wr, reg_rd, align_q} = '0;
    {field_clear, lock_sel} = 2'b11;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    void'($urandom(42889));
    tick(8);
    #1 `CHK("reset red", 1'b1, red)
    `CHK("reset oe", 1'b1, pin_oe)
    @(posedge clk) arst_n <= 1'b1;
    reg_rd_t(ril_pkg::ADDR_STATUS, d);
    `CHK("mode selftest", 3'h0, d[2:0])
    // Show phase opens 11 edges after release; default digit is zero
    tick(10);
    #1 `CHK("rt digit", 7'h3f, segs)
    tick(40);
    reg_rd_t(ril_pkg::ADDR_STATUS, d);
    `CHK("mode locked", 3'h2, d[2:0])
    `CHK("res enabled", 1'b1, d[4])
    chk_state(1'b0, 1'b1);
    @(posedge clk) field_clear <= 1'b0;
    tick(3);
    chk_state(1'b0, 1'b0);
    @(posedge clk) field_clear <= 1'b1;
    push($urandom_range(100, 400));
    chk_state(1'b0, 1'b1);
    push($urandom_range(2800, 3500));
    chk_state(1'b0, 1'b1);
    push($urandom_range(800, 2200));
    chk_state(1'b1, 1'b0);
    // Reduced margin: green must blink while outputs hold
    @(posedge clk) margin_low <= 1'b1;
    tick(3);
    for (int i = 0; i < 40; i++) begin
      @(posedge clk) #1;
      if (grn === 1'b1) n_hi++;
      if (grn === 1'b0) n_lo++;
    end
    `CHK("green blinks", 1'b1, n_hi > 0 && n_lo > 0)
    `CHK("on in margin", 1'b1, out_a)
    @(posedge clk) margin_low <= 1'b0;
    reg_wr_t(ril_pkg::ADDR_CTRL, 8'h01);
    reg_rd_t(ril_pkg::ADDR_CTRL, d);
    `CHK("ctrl rb", 8'h01, d)
    tick(1);
    #1 `CHK("rd idle", 8'h00, rdata)
    reg_rd_t(8'h20, d);
    `CHK("unmapped", 8'h00, d)
    for (int k = 0; k < 4; k++) begin
      @(posedge clk) align_q <= (k == 0) ? 3'h7 : 3'($urandom_range(1, 7));
      tick(3);
      n_hi = 0;
      for (int i = 0; i < 40; i++) begin
        @(posedge clk) #1;
        if (segs === bar(align_q)) n_hi++;
        else `CHK("seg off", 7'h00, segs)
      end
      `CHK("seg bar seen", 1'b1, n_hi > 0)
    end
    reg_wr_t(ril_pkg::ADDR_CTRL, 8'h00);
    tick(3);
    #1 `CHK("seg dis", 7'h00, segs)
    // Field break while on: both channels drop at the next edge
    @(posedge clk) field_clear <= 1'b0;
    @(posedge clk) #1;
    `CHK("brk a", 1'b0, out_a)
    `CHK("brk b", 1'b0, out_b)
    tick(3);
    chk_state(1'b0, 1'b0);
    @(posedge clk) field_clear <= 1'b1;
    tick(20);
    chk_state(1'b0, 1'b1);
    // Stuck button: fault, and a later valid press no longer unlocks
    @(posedge clk) press <= 1'b1;
    tick(SHORT_C + 300);
    reg_rd_t(ril_pkg::ADDR_STATUS, d);
    `CHK("mode fault", 3'h4, d[2:0])
    `CHK("stuck flag", 1'b1, d[6])
    @(posedge clk) press <= 1'b0;
    tick(300);
    push(1200);
    chk_state(1'b0, 1'b0);
    // Interlock bridged off: outputs follow the field alone
    @(posedge clk) lock_sel <= 1'b0;
    arst_n <= 1'b0;
    tick(3);
    #1 `CHK("mid rst out", 1'b0, out_a)
    `CHK("mid rst red", 1'b1, red)
    @(posedge clk) arst_n <= 1'b1;
    // First edges after release: still in self test, pin driven low
    tick(2);
    #1 `CHK("rst oe", 1'b1, pin_oe)
    `CHK("rst lamp", 1'b0, pin_o)
    tick(38);
    chk_state(1'b1, 1'b0);
    reg_rd_t(ril_pkg::ADDR_STATUS, d);
    `CHK("res off", 1'b0, d[4])
    @(posedge clk) field_clear <= 1'b0;
    tick(3);
    chk_state(1'b0, 1'b0);
    @(posedge clk) field_clear <= 1'b1;
    tick(3);
    chk_state(1'b1, 1'b0);
    `CHK("split", 0, split_cnt)
    end_of_test();
  end
endmodule : ril_restart_ctrl_tb
`default_nettype wire
